// >>> include/flash_rewrite_bus_control_regs.vh
`ifndef FLASH_REWRITE_BUS_CONTROL_REGS_VH
`define FLASH_REWRITE_BUS_CONTROL_REGS_VH
// timing word field positions
`define RBT_READ_WAIT_LSB 0
`define RBT_READ_WAIT_MSB 3
`define RBT_READ_EXT_BIT 4
`define RBT_SETUP_LSB 8
`define RBT_SETUP_MSB 9
`define RBT_WRITE_WAIT_LSB 10
`define RBT_WRITE_WAIT_MSB 11
`define RBT_MPY_LSB 6
`define RBT_MPY_MSB 7
// reset and recommended values
`define RBT_RESET_VALUE 16'h0000
`define RBT_RECOMMENDED 16'h5885
`define CSB_RESET_VALUE 8'h00
// multiplier codes
`define MPY_CODE_THREE 2'h2
`define MPY_CODE_FOUR 2'h3
`define MPY_THREE 3'h3
`define MPY_FOUR 3'h4
`define MPY_TWO 3'h2
// flash modes
`define FM_READ_ARRAY 2'h0
`define FM_READ_STATUS 2'h1
`define FM_BUSY 2'h2
// commands
`define CMD_PROGRAM 3'h1
`define CMD_BLOCK_ERASE 3'h2
`define CMD_LOCK_PROGRAM 3'h3
`define CMD_PROTECT_PROGRAM 3'h4
// status bits
`define FRS_READY_BIT 0
`define FRS_ABORT_BIT 1
`define FRS_ERASE_ERR_BIT 2
`define FRS_PROG_ERR_BIT 3
`define FRS_RESET_VALUE 8'h01
`define FLASH_MODE_REG_ZERO_RESET_VALUE 8'h00
`endif

// >>> design/flash_rewrite_bus_control.v
// How it works
// - extension bit zero adds no read lengthening
// - multiplier code 10b gives multiplier three
// - single-chip: timing zero serves both areas
// - expansion: zero times program, three data
// - rewrite and external timing share storage
// - after write in expansion, spaces 0/3 separate, 16-bit
// - rewrite mode in expansion ignores grant; muxed spaces blocked
// - four urgent interrupts abort the commands
// - aborted erase leaves lock bits undefined
// - urgent interrupt forces read array mode
// - abort resets mode zero and status zero
// - trap instructions unusable in rewrite mode
// - bad id code blocks serial flash access
// - after operation, stay in status mode
`include "flash_rewrite_bus_control_regs.vh"
module flash_rewrite_bus_control #(
    parameter OP_CYCLES = 64
) (
    input wire sys_clk,
    input wire arst_n,
    input wire memory_expansion,
    input wire rewrite_mode_enable,
    input wire timing_wr,
    input wire timing_sel_three,
    input wire [15:0] timing_wdata,
    input wire flash_access,
    input wire flash_access_data_area,
    input wire flash_access_write,
    input wire cmd_valid,
    input wire [2:0] cmd_code,
    input wire clear_status,
    input wire lock_protect_disable,
    input wire nmi_irq,
    input wire watchdog_irq,
    input wire osc_stop_irq,
    input wire low_voltage_irq,
    input wire bus_grant_req_pin,
    input wire serial_io_mode,
    input wire id_code_ok,
    input wire trap_fetch,
    output reg [15:0] rewrite_bus_timing_zero,
    output reg [15:0] rewrite_bus_timing_three,
    output reg [4:0] read_cycles,
    output reg [2:0] cycle_multiplier,
    output reg [1:0] write_setup_code,
    output reg [1:0] write_wait_code,
    output reg cs_override,
    output reg bus_grant_ack,
    output reg muxed_space_block,
    output reg [1:0] flash_mode,
    output reg [7:0] flash_mode_reg_zero,
    output reg [7:0] flash_ready_status_zero,
    output reg lock_bits_undefined,
    output reg trap_blocked,
    output reg serial_access_block,
    output reg cmd_aborted
);
    reg rst_meta;
    reg rst_sync;
    reg [1:0] grant_sync;
    reg [3:0] irq_meta;
    reg [3:0] irq_sync;
    reg [15:0] active_timing;
    reg [1:0] state;
    reg [2:0] cur_cmd;
    reg [7:0] op_count;
    reg [1:0] next_state;
    wire urgent_irq;
    wire abortable;
    wire [3:0] rd_code;
    wire rd_ext;
    wire [1:0] mpy_code;
    localparam ST_IDLE = 2'h0;
    localparam ST_BUSY = 2'h1;
    localparam ST_DONE = 2'h2;

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // interrupt lines arrive from other logic, synchronise
    always @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            irq_meta <= 4'h0;
            irq_sync <= 4'h0;
            grant_sync <= 2'h0;
        end else begin
            irq_meta <= {nmi_irq, watchdog_irq, osc_stop_irq,
                low_voltage_irq};
            irq_sync <= irq_meta;
            grant_sync <= {grant_sync[0],
                bus_grant_req_pin};
        end
    end

    assign urgent_irq = |irq_sync;
    assign abortable = (cur_cmd == `CMD_PROGRAM) ||
        (cur_cmd == `CMD_BLOCK_ERASE) ||
        (cur_cmd == `CMD_LOCK_PROGRAM) ||
        (cur_cmd == `CMD_PROTECT_PROGRAM);

    // one store per index serves both views
    always @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            rewrite_bus_timing_zero <= `RBT_RESET_VALUE;
            rewrite_bus_timing_three <= `RBT_RESET_VALUE;
            cs_override <= 1'b0;
        end else if (timing_wr) begin
            if (timing_sel_three)
                rewrite_bus_timing_three <= timing_wdata;
            else
                rewrite_bus_timing_zero <= timing_wdata;
            if (memory_expansion)
                cs_override <= 1'b1;
        end else if (!memory_expansion) begin
            cs_override <= 1'b0;
        end
    end

    // latch timing on every cycle that flash_access is high
    always @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            active_timing <= `RBT_RESET_VALUE;
        end else if (flash_access) begin
            if (memory_expansion && flash_access_data_area)
                active_timing <= rewrite_bus_timing_three;
            else
                active_timing <= rewrite_bus_timing_zero;
        end
    end

    assign rd_code = active_timing[`RBT_READ_WAIT_MSB:`RBT_READ_WAIT_LSB];
    assign rd_ext = active_timing[`RBT_READ_EXT_BIT];
    assign mpy_code = active_timing[`RBT_MPY_MSB:`RBT_MPY_LSB];

    // read wait index: codes 0,1,5,6,a,b,f give wr 1 to 7, others give 1
    function [2:0] wr_of;
        input [3:0] code;
        begin
            case (code)
                4'h0: wr_of = 3'h1;
                4'h1: wr_of = 3'h2;
                4'h5: wr_of = 3'h3;
                4'h6: wr_of = 3'h4;
                4'ha: wr_of = 3'h5;
                4'hb: wr_of = 3'h6;
                4'hf: wr_of = 3'h7;
                default: wr_of = 3'h1;
            endcase
        end
    endfunction

    // read cycle count for multipliers two and three, tcR column
    function [4:0] tcr_of;
        input [2:0] wr;
        input ext;
        begin
            case (wr)
                3'h1: tcr_of = ext ? 5'h06 : 5'h04;
                3'h2: tcr_of = 5'h08;
                3'h3: tcr_of = ext ? 5'h0c : 5'h0a;
                3'h4: tcr_of = 5'h0e;
                3'h5: tcr_of = ext ? 5'h12 : 5'h10;
                3'h6: tcr_of = 5'h14;
                3'h7: tcr_of = ext ? 5'h18 : 5'h16;
                default: tcr_of = 5'h04;
            endcase
        end
    endfunction

    // multiplier four ignores extension, 4*wr + 2
    function [4:0] tcr4_of;
        input [2:0] wr;
        begin
            tcr4_of = {wr, 2'b00} + 5'h02;
        end
    endfunction

    always @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            read_cycles <= 5'h04;
            cycle_multiplier <= `MPY_TWO;
            write_setup_code <= 2'h0;
            write_wait_code <= 2'h0;
        end else begin
            case (mpy_code)
                `MPY_CODE_THREE: cycle_multiplier <= `MPY_THREE;
                `MPY_CODE_FOUR: cycle_multiplier <= `MPY_FOUR;
                default: cycle_multiplier <= `MPY_TWO;
            endcase
            if (mpy_code == `MPY_CODE_FOUR)
                read_cycles <= tcr4_of(wr_of(rd_code));
            else
                read_cycles <= tcr_of(wr_of(rd_code), rd_ext);
            write_setup_code <=
                active_timing[`RBT_SETUP_MSB:`RBT_SETUP_LSB];
            write_wait_code <=
                active_timing[`RBT_WRITE_WAIT_MSB:`RBT_WRITE_WAIT_LSB];
        end
    end

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: if (cmd_valid && rewrite_mode_enable)
                next_state = ST_BUSY;
            ST_BUSY: if (urgent_irq && abortable)
                next_state = ST_IDLE;
            else if (op_count == OP_CYCLES[7:0])
                next_state = ST_DONE;
            ST_DONE: if (cmd_valid && rewrite_mode_enable)
                next_state = ST_BUSY;
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            state <= ST_IDLE;
            cur_cmd <= 3'h0;
            op_count <= 8'h00;
            flash_mode <= `FM_READ_ARRAY;
            flash_mode_reg_zero <= `FLASH_MODE_REG_ZERO_RESET_VALUE;
            flash_ready_status_zero <= `FRS_RESET_VALUE;
            lock_bits_undefined <= 1'b0;
            cmd_aborted <= 1'b0;
        end else begin
            state <= next_state;
            cmd_aborted <= 1'b0;
            if (clear_status)
                flash_ready_status_zero <= `FRS_RESET_VALUE;
            if (lock_protect_disable)
                lock_bits_undefined <= 1'b0;
            if (state != ST_BUSY && cmd_valid && rewrite_mode_enable) begin
                cur_cmd <= cmd_code;
                op_count <= 8'h00;
                flash_mode <= `FM_BUSY;
                flash_mode_reg_zero <= {5'h00, cmd_code};
                flash_ready_status_zero[`FRS_READY_BIT] <= 1'b0;
            end else if (state == ST_BUSY) begin
                if (urgent_irq && abortable) begin
                    // urgent interrupt back to read array
                    flash_mode <= `FM_READ_ARRAY;
                    flash_mode_reg_zero <= `FLASH_MODE_REG_ZERO_RESET_VALUE;
                    flash_ready_status_zero <= `FRS_RESET_VALUE;
                    cmd_aborted <= 1'b1;
                    if (cur_cmd == `CMD_BLOCK_ERASE)
                        lock_bits_undefined <= 1'b1;
                end else if (op_count == OP_CYCLES[7:0]) begin
                    flash_mode <= `FM_READ_STATUS;
                    flash_ready_status_zero[`FRS_READY_BIT] <= 1'b1;
                end else begin
                    op_count <= op_count + 8'h01;
                end
            end
        end
    end

    always @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            bus_grant_ack <= 1'b0;
            muxed_space_block <= 1'b0;
            trap_blocked <= 1'b0;
            serial_access_block <= 1'b0;
        end else begin
            // grant ignored while rewriting in expansion
            bus_grant_ack <= grant_sync[1] &&
                !(rewrite_mode_enable && memory_expansion);
            muxed_space_block <= rewrite_mode_enable && memory_expansion;
            trap_blocked <= rewrite_mode_enable && trap_fetch;
            // bad id code blocks serial access
            serial_access_block <= serial_io_mode && !id_code_ok;
        end
    end
endmodule // flash_rewrite_bus_control

// >>> tb/cpu_sw_model.sv
module cpu_sw_model (
    input wire sys_clk,
    input wire [1:0] flash_mode,
    output logic cmd_valid,
    output logic [2:0] cmd_code
);
    timeunit 1ns;
    timeprecision 1ps;
    initial cmd_valid = 1'b0;
    initial cmd_code = 3'h0;
    task automatic issue(input logic [2:0] code, input int slow);
        repeat (slow) @(posedge sys_clk);
        @(posedge sys_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_code = code;
        @(posedge sys_clk);
        #1;
        cmd_valid = 1'b0;
        // released code must not linger
        cmd_code = ~code;
    endtask
    task automatic wait_done(output logic ok);
        ok = 1'b0;
        for (int n = 0; n < 1000 && !ok; n++) begin
            @(posedge sys_clk);
            #1;
            ok = (flash_mode === 2'h1);
        end
    endtask
endmodule // cpu_sw_model

// >>> tb/flash_rewrite_bus_control_asserts.sv
module rewrite_checker #(
    parameter OP_CYCLES = 64
) (
    input wire sys_clk,
    input wire arst_n,
    input wire memory_expansion,
    input wire rewrite_mode_enable,
    input wire timing_wr,
    input wire timing_sel_three,
    input wire [15:0] timing_wdata,
    input wire flash_access,
    input wire flash_access_data_area,
    input wire cmd_valid,
    input wire [15:0] rewrite_bus_timing_zero,
    input wire [15:0] rewrite_bus_timing_three,
    input wire [4:0] read_cycles,
    input wire [2:0] cycle_multiplier,
    input wire cs_override,
    input wire bus_grant_ack,
    input wire [1:0] flash_mode,
    input wire [7:0] flash_mode_reg_zero,
    input wire [7:0] flash_ready_status_zero,
    input wire cmd_aborted
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // word the next access latches
    wire [15:0] word = (memory_expansion && flash_access_data_area) ?
        rewrite_bus_timing_three : rewrite_bus_timing_zero;
    cmd_start_a: assert property (
        cmd_valid && rewrite_mode_enable && flash_mode != 2'h2
        |=> flash_mode == 2'h2) else $error("command not taken");
    ready_set_a: assert property (
        flash_mode == 2'h1 && $past(flash_mode) == 2'h2
        |-> flash_ready_status_zero[0]) else $error("ready bit low");
    abort_reset_a: assert property (
        cmd_aborted |-> ##[0:1] (flash_mode == 2'h0 &&
        flash_mode_reg_zero == 8'h00 && flash_ready_status_zero == 8'h01))
        else $error("abort left state");
    timing_zero_a: assert property (
        timing_wr && !timing_sel_three
        |=> rewrite_bus_timing_zero == $past(timing_wdata))
        else $error("timing zero not written");
    timing_three_a: assert property (
        timing_wr && timing_sel_three
        |=> rewrite_bus_timing_three == $past(timing_wdata))
        else $error("timing three not written");
    mpy_three_a: assert property (
        flash_access && word[7:6] == 2'h2 |-> ##2 cycle_multiplier == 3'h3)
        else $error("multiplier not three");
    no_extend_a: assert property (
        flash_access && word[7:6] == 2'h2 && word[4:0] == 5'h05
        |-> ##2 read_cycles == 5'h0a) else $error("read pulse extended");
    cs_separate_a: assert property (
        timing_wr && memory_expansion |-> ##[1:2] cs_override)
        else $error("cs override missing");
    grant_ignore_a: assert property (
        (memory_expansion && rewrite_mode_enable) [*4] |-> !bus_grant_ack)
        else $error("grant honoured");
    cover property (cmd_aborted);
    cover property ($rose(cs_override));
    cover property (flash_mode == 2'h1 && $past(flash_mode) == 2'h2);
endmodule // rewrite_checker
bind flash_rewrite_bus_control rewrite_checker #(.OP_CYCLES(OP_CYCLES))
    rewrite_checker_inst (.sys_clk, .arst_n, .memory_expansion,
    .rewrite_mode_enable, .timing_wr, .timing_sel_three, .timing_wdata,
    .flash_access, .flash_access_data_area, .cmd_valid,
    .rewrite_bus_timing_zero, .rewrite_bus_timing_three, .read_cycles,
    .cycle_multiplier, .cs_override, .bus_grant_ack, .flash_mode,
    .flash_mode_reg_zero, .flash_ready_status_zero, .cmd_aborted);

// >>> tb/flash_rewrite_bus_control_test.sv
module flash_rewrite_bus_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic memory_expansion, rewrite_mode_enable, timing_wr, timing_sel_three;
    logic flash_access, flash_access_data_area, flash_access_write;
    logic clear_status, lock_protect_disable, bus_grant_req_pin;
    logic serial_io_mode, id_code_ok, trap_fetch, ok;
    logic [15:0] timing_wdata;
    logic [3:0] irq;
    wire cmd_valid, cs_override, bus_grant_ack, muxed_space_block;
    wire lock_bits_undefined, trap_blocked, serial_access_block, cmd_aborted;
    wire [2:0] cmd_code, cycle_multiplier;
    wire [15:0] rewrite_bus_timing_zero, rewrite_bus_timing_three;
    wire [4:0] read_cycles;
    wire [1:0] write_setup_code, write_wait_code, flash_mode;
    wire [7:0] flash_mode_reg_zero, flash_ready_status_zero;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    // short op keeps the run brief
    flash_rewrite_bus_control #(.OP_CYCLES(8)) flash_rewrite_bus_control_inst (
        .*, .nmi_irq(irq[0]), .watchdog_irq(irq[1]), .osc_stop_irq(irq[2]),
        .low_voltage_irq(irq[3]));
    cpu_sw_model cpu_sw_model_inst (.*);
    always #10 sys_clk = ~sys_clk;
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr_timing(input logic three, input logic [15:0] w);
        timing_wr = 1'b1;
        timing_sel_three = three;
        timing_wdata = w;
        step(1);
        timing_wr = 1'b0;
    endtask
    task automatic access(input logic data);
        flash_access = 1'b1;
        flash_access_data_area = data;
        step(1);
        flash_access = 1'b0;
        step(2);
    endtask
    initial begin
        {memory_expansion, rewrite_mode_enable, timing_wr, timing_sel_three,
            flash_access, flash_access_data_area, flash_access_write,
            clear_status, lock_protect_disable, bus_grant_req_pin,
            serial_io_mode, id_code_ok, trap_fetch} = '0;
        timing_wdata = 16'h0000;
        irq = 4'h0;
        step(16);
        arst_n = 1'b1;
        step(3);
        chk(rewrite_bus_timing_zero, 16'h0000);
        chk(16'(cycle_multiplier), 16'h0002);
        chk(16'(flash_ready_status_zero), 16'h0001);
        $display("test reset done");
        wr_timing(1'b0, 16'h5885);
        step(1);
        wr_timing(1'b1, 16'h0fc0);
        chk(rewrite_bus_timing_three, 16'h0fc0);
        access(1'b1);
        chk(16'(read_cycles), 16'h000a);
        chk(16'(write_setup_code), 16'h0000);
        chk(16'(cycle_multiplier), 16'h0003);
        chk(16'(write_wait_code), 16'h0002);
        memory_expansion = 1'b1;
        wr_timing(1'b0, 16'h0000);
        step(1);
        chk(16'(cs_override), 16'h0001);
        chk(16'(cycle_multiplier), 16'h0003);
        access(1'b1);
        chk(16'(cycle_multiplier), 16'h0004);
        chk(16'(read_cycles), 16'h0006);
        chk(16'(write_setup_code), 16'h0003);
        wr_timing(1'b0, 16'h5885);
        access(1'b0);
        chk(16'(cycle_multiplier), 16'h0003);
        $display("test timing done");
        rewrite_mode_enable = 1'b1;
        for (int c = 1; c <= 4; c++) begin
            cpu_sw_model_inst.issue(3'(c), c - 1);
            chk(16'(flash_mode), 16'h0002);
            cpu_sw_model_inst.wait_done(ok);
            chk(16'(flash_ready_status_zero[0] & ok), 16'h0001);
        end
        rewrite_mode_enable = 1'b0;
        cpu_sw_model_inst.issue(3'h1, 0);
        chk(16'(flash_mode), 16'h0001);
        rewrite_mode_enable = 1'b1;
        for (int i = 0; i < 4; i++) begin
            cpu_sw_model_inst.issue(3'h2, 0);
            irq[i] = 1'b1;
            step(4);
            chk(16'(flash_mode), 16'h0000);
            chk({flash_mode_reg_zero, flash_ready_status_zero}, 16'h0001);
            chk(16'(lock_bits_undefined), 16'h0001);
            irq[i] = 1'b0;
            lock_protect_disable = 1'b1;
            step(2);
            chk(16'(lock_bits_undefined), 16'h0000);
            lock_protect_disable = 1'b0;
            cpu_sw_model_inst.issue(3'h2, 0);
            cpu_sw_model_inst.wait_done(ok);
            chk(16'(ok), 16'h0001);
        end
        $display("test abort done");
        {bus_grant_req_pin, serial_io_mode, trap_fetch} = 3'h7;
        step(6);
        chk(16'(bus_grant_ack), 16'h0000);
        chk(16'(muxed_space_block), 16'h0001);
        chk(16'(trap_blocked), 16'h0001);
        chk(16'(serial_access_block), 16'h0001);
        rewrite_mode_enable = 1'b0;
        id_code_ok = 1'b1;
        step(6);
        chk(16'(bus_grant_ack), 16'h0001);
        chk(16'(muxed_space_block), 16'h0000);
        chk(16'(serial_access_block), 16'h0000);
        $display("test pins done");
        results();
    end
endmodule // flash_rewrite_bus_control_test
